/* File: design/rssc_pkg.sv */
// constants, types and decode helpers of the relay search sweep controller
package rssc_pkg;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 100_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_CFG    = 8'h04;
  localparam logic [7:0] OFF_RUNS   = 8'h08;
  localparam logic [7:0] OFF_JUDGE  = 8'h0c;
  localparam logic [7:0] OFF_TWAIT  = 8'h10;
  localparam logic [7:0] OFF_SWT    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_POS    = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_FAULT_BIT  = 0;
  localparam int CMD_NORMAL_BIT = 1;
  localparam int CMD_STOP_BIT   = 2;
  localparam int CFG_CUT_BIT    = 4;

  // ----------------------------------------------------------------
  // limits and reset values (times in tenths of a second)
  // ----------------------------------------------------------------
  localparam logic [3:0]  RUNS_MIN  = 4'h1;
  localparam logic [3:0]  RUNS_MAX  = 4'ha;
  localparam logic [3:0]  RUNS_RST  = 4'h3;
  localparam logic [6:0]  TIME_MIN  = 7'h01;
  localparam logic [6:0]  TIME_MAX  = 7'h64;
  localparam logic [6:0]  JUDGE_RST = 7'h01;
  localparam logic [6:0]  TWAIT_RST = 7'h01;
  localparam logic [13:0] SWT_MIN   = 14'h000a;
  localparam logic [13:0] SWT_MAX   = 14'h2710;
  localparam logic [13:0] SWT_RST   = 14'h0032;
  localparam logic [3:0]  DBL_MAX   = 4'ha;
  localparam int          FRAC_BITS = 10;
  localparam int          POS_W     = 24;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_PLAIN      = 3'h0;
  localparam logic [2:0] MODE_FAST_LIN   = 3'h1;
  localparam logic [2:0] MODE_FAST_GND   = 3'h2;
  localparam logic [2:0] MODE_FAST_SHORT = 3'h3;
  localparam logic [2:0] MODE_SLOW_LIN   = 3'h4;
  localparam logic [2:0] MODE_SLOW_GND   = 3'h5;
  localparam logic [2:0] MODE_SLOW_SHORT = 3'h6;

  typedef enum logic [1:0] {RSSC_PAT_LINEAR, RSSC_PAT_GROUND, RSSC_PAT_SHORT} rssc_pat_e;
  typedef enum logic [1:0] {RSSC_IDLE, RSSC_RUN, RSSC_JUDGE, RSSC_HOLD} rssc_state_e;

  function automatic logic rssc_is_fast(input logic [2:0] m);
    return (m >= MODE_FAST_LIN) && (m <= MODE_FAST_SHORT);
  endfunction

  function automatic logic rssc_is_slow(input logic [2:0] m);
    return (m >= MODE_SLOW_LIN) && (m <= MODE_SLOW_SHORT);
  endfunction

  function automatic rssc_pat_e rssc_pattern(input logic [2:0] m);
    case (m)
      MODE_FAST_GND, MODE_SLOW_GND:     return RSSC_PAT_GROUND;
      MODE_FAST_SHORT, MODE_SLOW_SHORT: return RSSC_PAT_SHORT;
      default:                          return RSSC_PAT_LINEAR;
    endcase
  endfunction

endpackage

/* File: design/rssc_sync.sv */
// two-stage synchroniser for the trip input
`timescale 1ns/1ps
`default_nettype none
module rssc_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } rssc_sync_s;

  rssc_sync_s r_reg;
  rssc_sync_s r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.meta = d_i;
    r_next.sync = r_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.sync;
endmodule
`default_nettype wire

/* File: design/rssc_tick.sv */
// timebase: one-cycle pulse every tick period
`timescale 1ns/1ps
`default_nettype none
module rssc_tick #(
  parameter int TICK_CYCLES = 10
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int CW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } rssc_tick_s;

  rssc_tick_s r_reg;
  rssc_tick_s r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == CW'(TICK_CYCLES - 1)) begin
      r_next.cnt  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick_o = r_reg.tick;
endmodule
`default_nettype wire

/* File: design/rssc_ctrl.sv */
// relay search sweep controller: wishbone registers and sweep sequencer
`timescale 1ns/1ps
`default_nettype none
// How it works
// - recovery sweep stops when trip goes off
// - fast search: linear, ground, short variants
// - slow search: same three variants
// - run count setting limited one to ten
// - judge time limited 0.1 to 10 s
// - trip wait used in slow search only
// - output cut option at search end
// - fast search suspends when trip changes
// - judge expiry: unchanged reverses, changed continues
// - each resumed run doubles sweep time, up to DBL_MAX doublings
// - fault start shows operate, count one
// - fault start finishes after set fault runs
// - normal start counts normal runs, recovery
// - no point found gives error, ends
// - slow search steps straight to fault
// - slow: after judge, trip on sweeps normal
// - slow resume direction from trip, doubling
// - slow counts fault runs, ends at setting
// - sweep time limited 1 to 1000 s
module rssc_ctrl
  import rssc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             trip_i,
  output logic                  out_enable_o,
  output logic      [POS_W-1:0] position_o,
  output logic      [1:0]       pattern_o,
  output logic                  toward_fault_o,
  output logic                  busy_o,
  output logic                  stop_ind_o,
  output logic                  error_ind_o,
  output logic                  operate_point_indication_o,
  output logic                  recover_point_indication_o,
  output logic      [3:0]       run_count_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rssc_state_e      st;
    logic [POS_W-1:0] pos;
    logic [3:0]       dbl;
    logic [6:0]       tmr;
    logic             dir;
    logic             cnt_dir;
    logic             trip_ref;
    logic             trip_susp;
    logic             first;
    logic             counted_done;
    logic [3:0]       run_cnt;
    logic             out_en;
    logic             stop_led;
    logic             err;
    logic             op_ind;
    logic             rec_ind;
    logic [2:0]       mode;
    logic             cut;
    logic [3:0]       runs;
    logic [6:0]       judge;
    logic [6:0]       twait;
    logic [13:0]      swt;
    logic             ack;
    logic [31:0]      dat;
  } rssc_ctrl_s;

  rssc_ctrl_s r_reg;
  rssc_ctrl_s r_next;
  logic       trip_s;
  logic       tick;

  rssc_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (trip_i),
    .q_o   (trip_s)
  );

  rssc_tick #(
    .TICK_CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic             do_wr;
    logic             start_f;
    logic             start_n;
    logic             stop_k;
    logic             fin;
    logic             fail;
    logic             rev;
    logic             ndir;
    logic [15:0]      m;
    logic [POS_W-1:0] full;
    logic [POS_W-1:0] step;
    do_wr   = r_reg.ack & wb_cyc_i & wb_stb_i & wb_we_i;
    start_f = do_wr & (wb_adr_i == OFF_CMD) & wb_sel_i[0] & wb_dat_i[CMD_FAULT_BIT];
    start_n = do_wr & (wb_adr_i == OFF_CMD) & wb_sel_i[0] & wb_dat_i[CMD_NORMAL_BIT]
              & ~wb_dat_i[CMD_FAULT_BIT];
    stop_k  = do_wr & (wb_adr_i == OFF_CMD) & wb_sel_i[0] & wb_dat_i[CMD_STOP_BIT];
    fin     = 1'b0;
    fail    = 1'b0;
    rev     = 1'b0;
    ndir    = r_reg.dir;
    m       = '0;
    full    = {r_reg.swt, 10'h000};
    step    = 24'h000001 << (DBL_MAX - r_reg.dbl);
    r_next  = r_reg;

    // bus slave: ack one cycle after the strobe, dropped the cycle after
    r_next.ack = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    case (wb_adr_i)
      OFF_CFG:    r_next.dat = {27'h0, r_reg.cut, 1'b0, r_reg.mode};
      OFF_RUNS:   r_next.dat = {28'h0, r_reg.runs};
      OFF_JUDGE:  r_next.dat = {25'h0, r_reg.judge};
      OFF_TWAIT:  r_next.dat = {25'h0, r_reg.twait};
      OFF_SWT:    r_next.dat = {18'h0, r_reg.swt};
      OFF_STATUS: r_next.dat = {18'h0, 2'(rssc_pattern(r_reg.mode)), r_reg.run_cnt, 1'b0,
                                r_reg.out_en, r_reg.dir, r_reg.rec_ind, r_reg.op_ind,
                                r_reg.err, r_reg.stop_led, r_reg.st != RSSC_IDLE};
      OFF_POS:    r_next.dat = {8'h0, r_reg.pos};
      default:    r_next.dat = 32'h0;
    endcase
    if (do_wr) begin
      m = merge16({2'b00, r_reg.swt}, wb_dat_i, wb_sel_i);
      case (wb_adr_i)
        OFF_CFG: begin
          if (wb_sel_i[0]) begin
            r_next.mode = (wb_dat_i[2:0] > MODE_SLOW_SHORT) ? MODE_PLAIN : wb_dat_i[2:0];
            r_next.cut  = wb_dat_i[CFG_CUT_BIT];
          end
        end
        OFF_RUNS: begin
          if (wb_sel_i[0]) begin
            r_next.runs = (wb_dat_i[3:0] < RUNS_MIN) ? RUNS_MIN :
                          (wb_dat_i[3:0] > RUNS_MAX) ? RUNS_MAX : wb_dat_i[3:0];
          end
        end
        OFF_JUDGE: begin
          if (wb_sel_i[0]) begin
            r_next.judge = (wb_dat_i[6:0] < TIME_MIN) ? TIME_MIN :
                           (wb_dat_i[6:0] > TIME_MAX) ? TIME_MAX : wb_dat_i[6:0];
          end
        end
        OFF_TWAIT: begin
          if (wb_sel_i[0]) begin
            r_next.twait = (wb_dat_i[6:0] < TIME_MIN) ? TIME_MIN :
                           (wb_dat_i[6:0] > TIME_MAX) ? TIME_MAX : wb_dat_i[6:0];
          end
        end
        OFF_SWT: begin
          r_next.swt = (m[13:0] < SWT_MIN || m[15:14] != 2'b00) ?
                       ((m[15:14] != 2'b00) ? SWT_MAX : SWT_MIN) :
                       (m[13:0] > SWT_MAX) ? SWT_MAX : m[13:0];
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // sweep sequencer
    // ----------------------------------------------------------------
    case (r_reg.st)
      RSSC_IDLE: begin
        if (start_f | start_n) begin
          r_next.stop_led     = 1'b0;
          r_next.err          = 1'b0;
          r_next.out_en       = 1'b1;
          r_next.run_cnt      = 4'h1;
          r_next.dbl          = 4'h0;
          r_next.tmr          = 7'h00;
          r_next.counted_done = 1'b0;
          r_next.cnt_dir      = start_f;
          r_next.op_ind       = start_f;
          r_next.rec_ind      = start_n;
          r_next.trip_ref     = trip_s;
          r_next.first        = 1'b0;
          if (rssc_is_slow(r_reg.mode)) begin
            r_next.pos   = full;
            r_next.dir   = 1'b0;
            r_next.first = 1'b1;
            r_next.st    = RSSC_HOLD;
          end else begin
            // fast search starts from the end opposite its direction
            if (rssc_is_fast(r_reg.mode)) begin
              r_next.pos = start_f ? '0 : full;
            end
            r_next.dir = start_f;
            r_next.st  = RSSC_RUN;
          end
        end
      end
      RSSC_RUN: begin
        if (trip_s != r_reg.trip_ref) begin
          if (r_reg.mode == MODE_PLAIN) begin
            fin = 1'b1;
          end else begin
            r_next.st        = RSSC_JUDGE;
            r_next.tmr       = 7'h00;
            r_next.trip_susp = trip_s;
          end
        end else if (r_reg.dir ? (r_reg.pos == full) : (r_reg.pos == '0)) begin
          fin  = 1'b1;
          fail = (r_reg.mode != MODE_PLAIN);
        end else if (tick) begin
          if (r_reg.dir) begin
            r_next.pos = (full - r_reg.pos <= step) ? full : r_reg.pos + step;
          end else begin
            r_next.pos = (r_reg.pos <= step) ? '0 : r_reg.pos - step;
          end
        end
      end
      RSSC_HOLD: begin
        // slow relays get the trip wait to pick up at the fault value
        if (trip_s) begin
          r_next.st        = RSSC_JUDGE;
          r_next.tmr       = 7'h00;
          r_next.trip_susp = 1'b1;
        end else if (tick) begin
          r_next.tmr = r_reg.tmr + 7'h01;
          if (r_reg.tmr + 7'h01 >= r_reg.twait) begin
            fin  = 1'b1;
            fail = 1'b1;
          end
        end
      end
      RSSC_JUDGE: begin
        if (r_reg.tmr >= r_reg.judge) begin
          if (r_reg.first) begin
            r_next.first = 1'b0;
            if (trip_s) begin
              r_next.st       = RSSC_RUN;
              r_next.dir      = 1'b0;
              r_next.trip_ref = 1'b1;
            end else begin
              fin  = 1'b1;
              fail = 1'b1;
            end
          end else begin
            rev  = (trip_s == r_reg.trip_susp);
            ndir = rev ? ~r_reg.dir : r_reg.dir;
            if (rev && (r_reg.dir == r_reg.cnt_dir) && (r_reg.run_cnt >= r_reg.runs)) begin
              fin = 1'b1;
            end else begin
              r_next.st       = RSSC_RUN;
              r_next.dir      = ndir;
              r_next.trip_ref = trip_s;
              r_next.dbl      = (r_reg.dbl == DBL_MAX) ? DBL_MAX : r_reg.dbl + 4'h1;
              if (rev && (r_reg.dir == r_reg.cnt_dir)) begin
                r_next.counted_done = 1'b1;
              end
              if (rev && (ndir == r_reg.cnt_dir) && r_reg.counted_done) begin
                r_next.run_cnt = r_reg.run_cnt + 4'h1;
              end
            end
          end
        end else if (tick) begin
          r_next.tmr = r_reg.tmr + 7'h01;
        end
      end
      default: r_next.st = RSSC_IDLE;
    endcase

    if (stop_k && r_reg.st != RSSC_IDLE) begin
      fin  = 1'b1;
      fail = 1'b0;
    end
    if (fin) begin
      r_next.st       = RSSC_IDLE;
      r_next.stop_led = 1'b1;
      r_next.err      = fail;
      if (r_reg.mode != MODE_PLAIN) begin
        r_next.out_en = ~r_reg.cut;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg        <= '0;
      r_reg.st     <= RSSC_IDLE;
      r_reg.out_en <= 1'b1;
      r_reg.runs   <= RUNS_RST;
      r_reg.judge  <= JUDGE_RST;
      r_reg.twait  <= TWAIT_RST;
      r_reg.swt    <= SWT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o                   = r_reg.ack;
  assign wb_dat_o                   = r_reg.dat;
  assign out_enable_o               = r_reg.out_en;
  assign position_o                 = r_reg.pos;
  assign pattern_o                  = 2'(rssc_pattern(r_reg.mode));
  assign toward_fault_o             = r_reg.dir;
  assign busy_o                     = (r_reg.st != RSSC_IDLE);
  assign stop_ind_o                 = r_reg.stop_led;
  assign error_ind_o                = r_reg.err;
  assign operate_point_indication_o = r_reg.op_ind;
  assign recover_point_indication_o = r_reg.rec_ind;
  assign run_count_o                = r_reg.run_cnt;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_plain_stop;
    (r_reg.st == RSSC_RUN && r_reg.mode == MODE_PLAIN && !r_reg.dir && r_reg.trip_ref
     && !trip_s) |=> (!busy_o && stop_ind_o && !error_ind_o);
  endproperty
  a_plain_stop: assert property (p_plain_stop) else $error("plain sweep not stopped");

  property p_runs_range;
    run_count_o <= RUNS_MAX && r_reg.runs >= RUNS_MIN && r_reg.runs <= RUNS_MAX;
  endproperty
  a_runs_range: assert property (p_runs_range) else $error("run count out of range");

  property p_judge_range;
    r_reg.judge >= TIME_MIN && r_reg.judge <= TIME_MAX;
  endproperty
  a_judge_range: assert property (p_judge_range) else $error("judge time out of range");

  property p_fast_suspend;
    (r_reg.st == RSSC_RUN && rssc_is_fast(r_reg.mode) && r_reg.dir && !r_reg.trip_ref
     && trip_s) |=> (r_reg.st == RSSC_JUDGE && r_reg.tmr == 7'h00 && r_reg.trip_susp);
  endproperty
  a_fast_suspend: assert property (p_fast_suspend) else $error("no suspend on trip");

  property p_double;
    (r_reg.st == RSSC_JUDGE && !r_reg.first) ##1 (r_reg.st == RSSC_RUN)
      |-> (r_reg.dbl == $past(r_reg.dbl) + 4'h1 || r_reg.dbl == DBL_MAX);
  endproperty
  a_double: assert property (p_double) else $error("sweep time not doubled");

  property p_cut;
    ($fell(busy_o) && r_reg.mode != MODE_PLAIN) |-> (out_enable_o == !r_reg.cut && stop_ind_o);
  endproperty
  a_cut: assert property (p_cut) else $error("output cut not applied");

  property p_slow_step;
    (r_reg.st == RSSC_IDLE && rssc_is_slow(r_reg.mode) && $changed(r_reg.mode) == 1'b0)
      ##1 (r_reg.st == RSSC_HOLD) |-> (position_o == {r_reg.swt, 10'h000} && run_count_o == 4'h1);
  endproperty
  a_slow_step: assert property (p_slow_step) else $error("no step to fault");

  property p_judge_wait;
    (r_reg.st == RSSC_JUDGE && r_reg.tmr < r_reg.judge) |=> (r_reg.st == RSSC_JUDGE || !busy_o);
  endproperty
  a_judge_wait: assert property (p_judge_wait) else $error("judge time cut short");

  c_fast_done: cover property ($fell(busy_o) && rssc_is_fast(r_reg.mode) && !error_ind_o);
  c_slow_done: cover property ($fell(busy_o) && rssc_is_slow(r_reg.mode) && !error_ind_o);
  c_error:     cover property ($rose(error_ind_o));
  c_second:    cover property ($rose(run_count_o == 4'h2));
endmodule
`default_nettype wire

/* File: verif/rssc_relay_model.sv */
// behavioural relay under test: trip contact follows drive level against pickup
`timescale 1ns/1ps
`default_nettype none
module rssc_relay_model
  import rssc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic [POS_W-1:0] position_i,
  input  wire logic [POS_W-1:0] pickup_i,
  output logic                  trip_o
);
  initial trip_o = 1'b0;
  // contact settles one cycle after the level crosses pickup, no hysteresis
  always @(posedge clk_i) begin
    trip_o <= (position_i >= pickup_i);
  end
endmodule
`default_nettype wire

/* File: verif/rssc_ctrl_bench.sv */
// self-checking bench of the relay search sweep controller
`timescale 1ns/1ps
`default_nettype none
module rssc_ctrl_bench;
  import rssc_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [3:0]       sel = 4'h0;
  logic [31:0]      dat = 32'h0;
  logic [31:0]      rd;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o, trip, out_en, busy_o, stop_o, err_o, op_o, rec_o, dir_o;
  logic [POS_W-1:0] pos, pickup = 24'hffffff;
  logic [1:0]       pat;
  logic [3:0]       cnt;
  int               errors = 0;
  int               checked = 0;
  int               cycles = 0;
  logic [7:0]       offs [7] = '{OFF_RUNS, OFF_RUNS, OFF_JUDGE, OFF_JUDGE, OFF_TWAIT,
                                 OFF_SWT, OFF_SWT};
  logic [31:0]      wval [7] = '{0, 15, 0, 127, 5, 20000, 5};
  logic [31:0]      eval [7] = '{1, 10, 1, 100, 5, 10000, 10};

  initial forever #5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  rssc_ctrl #(.TICK_CYCLES_P(10)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .trip_i(trip), .out_enable_o(out_en), .position_o(pos),
    .pattern_o(pat), .toward_fault_o(dir_o), .busy_o(busy_o), .stop_ind_o(stop_o),
    .error_ind_o(err_o), .operate_point_indication_o(op_o),
    .recover_point_indication_o(rec_o), .run_count_o(cnt));
  rssc_relay_model relay (.clk_i(clk_i), .position_i(pos), .pickup_i(pickup), .trip_o(trip));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic single cycle; read data taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    // no local limit: only the cycle ceiling ends a hung access
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // pickup moves only once the start is taken, so the start sees the parked contact
  task automatic run(input logic [31:0] cmd, input logic [POS_W-1:0] pk);
    wb(1'b1, OFF_CMD, cmd);
    pickup <= pk;
    do begin
      @(posedge clk_i);
    end while (busy_o !== 1'b0);
  endtask

  // final level must sit within one base step of the pickup
  task automatic near_pickup();
    int d;
    d = int'(pos) - int'(pickup);
    check({31'h0, (d < 1024 && d > -1024)}, 32'h1);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int               m, runs, cut, seed;
    logic [POS_W-1:0] pk;
    seed = $urandom(78);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFF_RUNS, 0);
    check(rd, 32'h3);
    wb(1'b0, OFF_JUDGE, 0);
    check(rd, 32'h1);
    wb(1'b0, OFF_SWT, 0);
    check(rd, 32'h32);
    wb(1'b0, 8'h20, 0);
    check(rd, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, offs[i], wval[i]);
      wb(1'b0, offs[i], 0);
      check(rd, eval[i]);
    end
    // advised timing also keeps the run short
    wb(1'b1, OFF_SWT, 32'h32);
    wb(1'b1, OFF_JUDGE, 32'h1);
    $display("settings test done");
    // every search mode, operate start, random pickup and run count
    for (m = 1; m <= 6; m++) begin
      cut = m % 2;
      runs = 1 + ($urandom % 3);
      pk = 24'(3000 + ($urandom % 4000));
      // contact parked off so an operate start begins from the idle level
      pickup <= 24'hffffff;
      wb(1'b1, OFF_CFG, 32'(cut * 16 + m));
      wb(1'b1, OFF_RUNS, 32'(runs));
      run(32'h1, pk);
      check({30'h0, pat}, 32'((m - 1) % 3));
      check({28'h0, cnt}, 32'(runs));
      check({26'h0, err_o, op_o, rec_o, stop_o, out_en, busy_o},
            {26'h0, 3'b010, 1'b1, 1'(cut == 0), 1'b0});
      near_pickup();
      if (m <= 3) begin
        run(32'h2, pk);
        check({28'h0, rec_o, op_o, stop_o, err_o}, 32'ha);
        check({28'h0, cnt}, 32'(runs));
        near_pickup();
      end
      $display("search mode %0d test done", m);
    end
    // no point found
    pickup <= 24'hffffff;
    wb(1'b1, OFF_CFG, 32'h1);
    run(32'h1, 24'hffffff);
    check({30'h0, err_o, busy_o}, 32'h2);
    $display("error test done");
    // stop key while a search sweep is under way
    wb(1'b1, OFF_CMD, 32'h1);
    wb(1'b1, OFF_CMD, 32'h4);
    wb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h16a);
    check({31'h0, dir_o}, 32'h1);
    $display("stop test done");
    // plain recovery sweep from the fault end
    wb(1'b1, OFF_CFG, 32'h0);
    run(32'h1, 24'hffffff);
    pickup <= 24'd5000;
    repeat (3) @(posedge clk_i);
    run(32'h2, 24'd5000);
    check({31'h0, stop_o}, 32'h1);
    check({31'h0, (pos < pickup && pos + 24'd1024 > pickup)}, 32'h1);
    $display("plain sweep test done");
    complete_run();
  end
endmodule
`default_nettype wire
